/* File: rtl/uart_regs.vh */
// Register offsets, field positions and reset values of the serial port.
// Assumes a 4-bit word-index address on the plain register port.
`ifndef UART_REGS_VH
`define UART_REGS_VH
`define A_BAUD 4'h0
`define A_CTRL 4'h1
`define A_STAT 4'h2
`define A_DATA 4'h3
`define BAUD_RST 13'h0000
`define CTRL_RST 10'h000
`define C_SBK 0
`define C_RXEN 1
`define C_TXEN 2
`define C_RIE 3
`define C_TX_DONE_IRQ_EN 4
`define C_TIE 5
`define C_ODS 6
`define C_NINE 7
`define C_PEN 8
`define C_PODD 9
`define S_PF 0
`define S_FF 1
`define S_NF 2
`define S_OVR 3
`define S_RBF 4
`define S_TDN 5
`define S_TBE 6
`define SAMPLES_PER_BIT 4'hF
`define MID_A 4'h7
`define MID_B 4'h8
`define MID_C 4'h9
`define START_ONES 2'h3
`endif

/* File: rtl/line_sync.v */
// Three-stage synchroniser for the serial input pin.
// Assumes the pin is asynchronous to CLK; output is a filtered level.
`timescale 1ns/1ps
module line_sync (
   input wire clk, // System clock
   input wire rst_n, // Async reset, active low
   input wire d, // Raw pin
   output reg lvl // Settled level
);
   reg s1_q;
   reg s2_q;
   reg s3_q;

   // Level changes only once stages two and three agree
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
         s3_q <= 1'b1;
         lvl <= 1'b1;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            lvl <= s3_q;
         end
      end
   end
endmodule

/* File: rtl/rate_gen.v */
// Modulus rate generator giving a sample tick at sixteen times the bit rate.
// Assumes the divisor is static while the port is running.
`timescale 1ns/1ps
module rate_gen #(
   parameter DW = 13 // Divisor width
) (
   input wire clk, // System clock
   input wire rst_n, // Async reset, active low
   input wire [DW-1:0] div, // Bit rate divisor
   output reg tick // One-cycle sample tick
);
   reg [DW:0] cnt_q;
   wire [DW:0] top = {div, 1'b0} - {{DW{1'b0}}, 1'b1};

   // tick every 2*div clocks, i.e. 16x bit rate
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= {(DW+1){1'b0}};
         tick <= 1'b0;
      end else if (div == {DW{1'b0}}) begin
         cnt_q <= {(DW+1){1'b0}};
         tick <= 1'b0;
      end else if (cnt_q >= top) begin
         cnt_q <= {(DW+1){1'b0}};
         tick <= 1'b1;
      end else begin
         cnt_q <= cnt_q + {{DW{1'b0}}, 1'b1};
         tick <= 1'b0;
      end
   end
endmodule

/* File: rtl/async_serial_port.v */
// Asynchronous serial transmitter and receiver with its register file.
// Assumes a single-cycle register port; read data valid the next cycle.
`timescale 1ns/1ps
`include "uart_regs.vh"
module async_serial_port (
   input wire CLK, // System clock, 125 MHz
   input wire RST_N, // Async reset, active low
   input wire [3:0] ADDR, // Register index
   input wire [15:0] WDATA, // Write data
   input wire WR, // Write strobe
   input wire RD, // Read strobe
   output reg [15:0] RDATA, // Read data, cycle after RD
   input wire RXD, // Serial input pin
   output reg TXD_O, // Serial output level
   output reg TXD_OE_N, // Low while driving the pin
   output reg TX_ACTIVE, // High while transmitter owns the pin
   output reg IRQ // Interrupt request level
);
   localparam K_DATA = 2'd0;
   localparam K_IDLE = 2'd1;
   localparam K_BRK = 2'd2;
   localparam K_MARK = 2'd3;
   localparam R_IDLE = 2'd0;
   localparam R_START = 2'd1;
   localparam R_BITS = 2'd2;
   localparam R_STOP = 2'd3;

   reg [12:0] baud_q;
   reg [9:0] ctrl_q;
   wire stick;
   wire rxl;

   wire send_break = ctrl_q[`C_SBK];
   wire rx_en = ctrl_q[`C_RXEN];
   wire tx_en = ctrl_q[`C_TXEN];
   wire nine = ctrl_q[`C_NINE];
   wire pen = ctrl_q[`C_PEN];
   wire podd = ctrl_q[`C_PODD];

   rate_gen #(.DW(13)) u_rate (
      .clk(CLK),
      .rst_n(RST_N),
      .div(baud_q),
      .tick(stick)
   );

   line_sync u_sync (
      .clk(CLK),
      .rst_n(RST_N),
      .d(RXD),
      .lvl(rxl)
   );

   // Status flags and clear arming
   reg tbe_q;
   reg tdn_q;
   reg rbf_q;
   reg ovr_q;
   reg nf_q;
   reg ff_q;
   reg pf_q;
   reg [6:0] arm_q;
   wire [6:0] stat = {tbe_q, tdn_q, rbf_q, ovr_q, nf_q, ff_q, pf_q};

   wire wr_baud = WR && (ADDR == `A_BAUD);
   wire wr_ctrl = WR && (ADDR == `A_CTRL);
   wire wr_stat = WR && (ADDR == `A_STAT);
   wire wr_data = WR && (ADDR == `A_DATA);
   wire rd_stat = RD && (ADDR == `A_STAT);
   wire rd_data = RD && (ADDR == `A_DATA);

   // Transmitter state
   reg [8:0] hold_q;
   reg [10:0] tsh_q;
   reg [3:0] tcnt_q;
   reg [3:0] tph_q;
   reg tbusy_q;
   reg [1:0] kind_q;
   reg brk_last_q;
   reg pre_q;
   reg txen_d1_q;

   wire btick = stick && (tph_q == `SAMPLES_PER_BIT);
   wire fend = btick && (!tbusy_q || tcnt_q == 4'h1);

   // parity over character bits, inverted for odd
   // msb of the character carries parity
   wire par7 = ^hold_q[6:0] ^ podd;
   wire par8 = ^hold_q[7:0] ^ podd;
   wire [8:0] tchr = !pen ? hold_q :
                     nine ? {par8, hold_q[7:0]} : {1'b0, par7, hold_q[6:0]};
   // frame of 10 or 11 bits by nine_bit_sel
   wire [10:0] tfrm = nine ? {1'b1, tchr, 1'b0} :
                      {2'b11, tchr[7:0], 1'b0};
   wire [3:0] tlen = nine ? 4'hB : 4'hA;

   // Frame selection when the shifter frees up
   reg nx_go;
   reg [1:0] nx_kind;
   reg nx_load;
   reg nx_done;
   always @* begin
      nx_go = 1'b0;
      nx_kind = K_DATA;
      nx_load = 1'b0;
      nx_done = 1'b0;
      if (fend) begin
         if (!tx_en) begin
            nx_done = tbusy_q;
         end else if (send_break) begin
            nx_go = 1'b1;
            nx_kind = K_BRK;
         end else if (brk_last_q) begin
            nx_go = 1'b1;
            nx_kind = K_MARK;
            nx_done = 1'b1;
         end else if (pre_q) begin
            nx_go = 1'b1;
            nx_kind = K_IDLE;
         end else if (!tbe_q) begin
            nx_go = 1'b1;
            nx_load = 1'b1;
            nx_done = tbusy_q && (kind_q == K_IDLE);
         end else begin
            nx_done = tbusy_q;
         end
      end
   end

   // Transmit shifter, bit phase and frame bookkeeping
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         tsh_q <= 11'h7FF;
         tcnt_q <= 4'h0;
         tph_q <= 4'h0;
         tbusy_q <= 1'b0;
         kind_q <= K_DATA;
         brk_last_q <= 1'b0;
         pre_q <= 1'b0;
         txen_d1_q <= 1'b0;
      end else begin
         txen_d1_q <= tx_en;
         if (stick) begin
            tph_q <= tph_q + 4'h1;
         end
         if (tx_en && !txen_d1_q) begin
            pre_q <= 1'b1;
         end else if (nx_go && nx_kind == K_IDLE) begin
            pre_q <= 1'b0;
         end
         if (fend) begin
            tbusy_q <= nx_go;
            kind_q <= nx_kind;
            brk_last_q <= nx_go && (nx_kind == K_BRK);
            if (!nx_go) begin
               tsh_q <= 11'h7FF;
               tcnt_q <= 4'h0;
            end else if (nx_kind == K_BRK) begin
               tsh_q <= 11'h000;
               tcnt_q <= tlen;
            end else if (nx_kind == K_DATA) begin
               tsh_q <= tfrm;
               tcnt_q <= tlen;
            end else begin
               tsh_q <= 11'h7FF;
               tcnt_q <= (nx_kind == K_MARK) ? 4'h1 : tlen;
            end
         end else if (btick) begin
            tsh_q <= {1'b1, tsh_q[10:1]};
            tcnt_q <= tcnt_q - 4'h1;
         end
      end
   end

   // Receiver state
   reg [1:0] rst_q;
   reg [3:0] rph_q;
   reg [1:0] ones_q;
   reg [3:0] rcnt_q;
   reg [8:0] rsh_q;
   reg [2:0] smp_q;
   reg rprev_q;
   reg rnoise_q;
   reg [8:0] rdr_q;

   wire [2:0] smp_n = {smp_q[1:0], rxl};
   wire maj = (smp_n[0] & smp_n[1]) | (smp_n[1] & smp_n[2]) |
              (smp_n[0] & smp_n[2]);
   wire disagree = !(&smp_n) && (|smp_n);
   wire decide = stick && (rph_q == `MID_C);
   wire [8:0] rchr = nine ? rsh_q : {1'b0, rsh_q[8:1]};
   wire rpf = pen && ((^rchr) != podd);
   wire rdone = decide && (rst_q == R_STOP);
   wire rx_fault = rdone && !maj;
   wire rx_noise = rnoise_q || (decide && disagree);
   wire rx_ovr = rdone && rbf_q;
   wire rx_move = rdone && !rbf_q;

   // Receive bit processor on the sample tick
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_q <= R_IDLE;
         rph_q <= 4'h0;
         ones_q <= 2'h0;
         rcnt_q <= 4'h0;
         rsh_q <= 9'h000;
         smp_q <= 3'h7;
         rprev_q <= 1'b1;
         rnoise_q <= 1'b0;
      end else if (!rx_en) begin
         rst_q <= R_IDLE;
         ones_q <= 2'h0;
         rprev_q <= 1'b1;
      end else if (stick) begin
         rprev_q <= rxl;
         smp_q <= smp_n;
         case (rst_q)
            R_IDLE: begin
               if (rxl) begin
                  if (ones_q != `START_ONES) begin
                     ones_q <= ones_q + 2'h1;
                  end
               end else if (ones_q == `START_ONES) begin
                  rst_q <= R_START;
                  rph_q <= 4'h1;
                  rnoise_q <= 1'b0;
               end else begin
                  ones_q <= 2'h0;
               end
            end
            R_START: begin
               rph_q <= rph_q + 4'h1;
               if (decide) begin
                  rnoise_q <= disagree;
                  if (maj) begin
                     rst_q <= R_IDLE;
                     ones_q <= 2'h0;
                  end else begin
                     rst_q <= R_BITS;
                     rcnt_q <= nine ? 4'h9 : 4'h8;
                  end
               end
            end
            R_BITS: begin
               if (rxl != rprev_q) begin
                  rph_q <= 4'h1;
               end else begin
                  rph_q <= rph_q + 4'h1;
               end
               if (decide) begin
                  rnoise_q <= rx_noise;
                  rsh_q <= {maj, rsh_q[8:1]};
                  rcnt_q <= rcnt_q - 4'h1;
                  if (rcnt_q == 4'h1) begin
                     rst_q <= R_STOP;
                  end
               end
            end
            default: begin
               rph_q <= rph_q + 4'h1;
               if (decide) begin
                  rst_q <= R_IDLE;
                  ones_q <= maj ? 2'h1 : 2'h0;
               end
            end
         endcase
      end
   end

   // Registers, flags and the clear sequence
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         baud_q <= `BAUD_RST;
         ctrl_q <= `CTRL_RST;
         hold_q <= 9'h000;
         rdr_q <= 9'h000;
         tbe_q <= 1'b1;
         tdn_q <= 1'b1;
         rbf_q <= 1'b0;
         ovr_q <= 1'b0;
         nf_q <= 1'b0;
         ff_q <= 1'b0;
         pf_q <= 1'b0;
         arm_q <= 7'h00;
      end else begin
         if (wr_baud) begin
            baud_q <= WDATA[12:0];
         end
         if (wr_ctrl) begin
            ctrl_q <= WDATA[9:0];
         end
         if (wr_data) begin
            hold_q <= WDATA[8:0];
         end
         if (rd_stat) begin
            arm_q <= stat;
         end else if (rd_data) begin
            arm_q <= arm_q & 7'h60;
         end else if (wr_data) begin
            arm_q <= arm_q & 7'h1F;
         end
         // set on transfer wins over clear
         if (nx_load || (!tx_en && !tbusy_q)) begin
            tbe_q <= 1'b1;
         end else if (wr_stat || (wr_data && arm_q[`S_TBE])) begin
            tbe_q <= 1'b0;
         end
         // set at shift end, armed clear
         if (nx_done) begin
            tdn_q <= 1'b1;
         end else if (wr_data && arm_q[`S_TDN]) begin
            tdn_q <= 1'b0;
         end
         if (rx_move) begin
            rdr_q <= rchr;
            rbf_q <= 1'b1;
         end else if (rd_data && arm_q[`S_RBF]) begin
            rbf_q <= 1'b0;
         end
         if (rx_ovr) begin
            ovr_q <= 1'b1;
         end else if (rd_data && arm_q[`S_OVR]) begin
            ovr_q <= 1'b0;
         end
         if (rx_move && rx_noise) begin
            nf_q <= 1'b1;
         end else if (rd_data && arm_q[`S_NF]) begin
            nf_q <= 1'b0;
         end
         if (rx_move && rx_fault) begin
            ff_q <= 1'b1;
         end else if (rd_data && arm_q[`S_FF]) begin
            ff_q <= 1'b0;
         end
         if (rx_move && rpf) begin
            pf_q <= 1'b1;
         end else if (rd_data && arm_q[`S_PF]) begin
            pf_q <= 1'b0;
         end
      end
   end

   // Read data and registered pin and interrupt outputs
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         RDATA <= 16'h0000;
         TXD_O <= 1'b1;
         TXD_OE_N <= 1'b1;
         TX_ACTIVE <= 1'b0;
         IRQ <= 1'b0;
      end else begin
         if (RD && ADDR == `A_BAUD) begin
            RDATA <= {3'b000, baud_q};
         end else if (RD && ADDR == `A_CTRL) begin
            RDATA <= {6'h00, ctrl_q};
         end else if (rd_stat) begin
            RDATA <= {9'h000, stat};
         end else if (rd_data) begin
            RDATA <= {7'h00, rdr_q};
         end else begin
            RDATA <= 16'h0000;
         end
         TX_ACTIVE <= tx_en || tbusy_q;
         TXD_O <= tsh_q[0];
         TXD_OE_N <= !((tx_en || tbusy_q) &&
                       (!ctrl_q[`C_ODS] || !tsh_q[0]));
         IRQ <= (tbe_q && ctrl_q[`C_TIE]) ||
                (tdn_q && ctrl_q[`C_TX_DONE_IRQ_EN]) ||
                (rbf_q && ctrl_q[`C_RIE]);
      end
   end
endmodule

/* File: testbench/async_serial_port_asserts.sv */
// Pin-level checks on the serial port, bound to its top module.
// Assumes only top ports are visible; enables are shadowed from writes.
`timescale 1ns/1ps
`include "uart_regs.vh"
module async_serial_port_asserts (
   input wire logic CLK, // Clock
   input wire logic RST_N, // Reset, active low
   input wire logic [3:0] ADDR, // Register index
   input wire logic [15:0] WDATA, // Write data
   input wire logic WR, // Write strobe
   input wire logic RD, // Read strobe
   input wire logic [15:0] RDATA, // Read data
   input wire logic RXD, // Serial in
   input wire logic TXD_O, // Serial out
   input wire logic TXD_OE_N, // Drive enable, low
   input wire logic TX_ACTIVE, // Pin owned
   input wire logic IRQ // Request
);
   logic [9:0] ctrl_q;
   default clocking dc @(posedge CLK);
   endclocking
   default disable iff (!RST_N);
   // Shadow of the control word, since the pins cannot show the enables
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N)
         ctrl_q <= 10'h000;
      else if (WR && ADDR == `A_CTRL)
         ctrl_q <= WDATA[9:0];
   end
   // Read port answers only in the cycle after a read strobe
   a_rdata_quiet: assert property (!RD |=> RDATA == 16'h0000)
      else $error("read data not zero outside a read");
   a_stat_upper: assert property (
      RD && ADDR == `A_STAT |=> RDATA[15:7] == 9'h000)
      else $error("status read shows reserved bits");
   a_unmapped_zero: assert property (
      RD && ADDR > `A_DATA |=> RDATA == 16'h0000)
      else $error("unmapped read not zero");
   a_ctrl_readback: assert property (
      WR && ADDR == `A_CTRL ##1 !WR ##1 RD && ADDR == `A_CTRL
      |=> RDATA[9:0] == $past(WDATA[9:0], 3))
      else $error("control word does not read back");
   // Pin ownership; one cycle of slack where two registers change together
   a_pin_release: assert property (
      !TX_ACTIVE && !$past(TX_ACTIVE) |-> TXD_OE_N)
      else $error("pin driven while transmitter idle");
   a_drive_owner: assert property (
      !TXD_OE_N && !$past(TXD_OE_N) |-> TX_ACTIVE)
      else $error("pin driven without ownership");
   // A bit lasts 32 clocks or more, so no level change follows soon
   a_bit_hold: assert property (
      TX_ACTIVE && $past(TX_ACTIVE) && !TXD_OE_N && $changed(TXD_O)
      |=> $stable(TXD_O) [*8])
      else $error("serial bit shorter than allowed");
   a_irq_follows: assert property (
      RD && ADDR == `A_STAT ##1 (RDATA[4] && ctrl_q[`C_RIE]
      || RDATA[5] && ctrl_q[`C_TX_DONE_IRQ_EN] || RDATA[6] && ctrl_q[`C_TIE])
      |-> IRQ)
      else $error("enabled flag set without request");
   c_rx_full: cover property (RD && ADDR == `A_STAT ##1 RDATA[4]);
   c_irq: cover property ($rose(IRQ));
   c_break: cover property ((!TXD_O && !TXD_OE_N) [*8]);
endmodule
bind async_serial_port async_serial_port_asserts chk (.CLK(CLK),
   .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
   .RDATA(RDATA), .RXD(RXD), .TXD_O(TXD_O), .TXD_OE_N(TXD_OE_N),
   .TX_ACTIVE(TX_ACTIVE), .IRQ(IRQ));

/* File: testbench/serial_peer.sv */
// Remote serial device: sends frames on the receive pin, catches sent ones.
// Assumes a bit lasts BIT clocks and the line idles at mark.
`timescale 1ns/1ps
module serial_peer #(
   parameter int BIT = 32 // Clocks per bit
) (
   input wire logic clk, // System clock
   input wire logic line, // Resolved transmit line
   output logic rxd // Receive pin of the port
);
   initial rxd = 1'b1;
   task automatic send(input logic [8:0] c, input int n, input logic s);
      rxd <= 1'b0;
      repeat (BIT) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         rxd <= c[i];
         repeat (BIT) @(posedge clk);
      end
      rxd <= s;
      repeat (BIT) @(posedge clk);
      rxd <= 1'b1;
      repeat (BIT) @(posedge clk);
   endtask
   task automatic catch(output logic [8:0] c, input int n, output logic s);
      c = 9'h000;
      @(negedge line);
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         repeat (BIT) @(posedge clk);
         c[i] = line;
      end
      repeat (BIT) @(posedge clk);
      s = line;
   endtask
endmodule

/* File: testbench/async_serial_port_bench.sv */
// Self-checking bench for the serial port, one task per scenario.
// Assumes divisor 1, so a bit lasts 32 clocks; line has a pull-up.
`timescale 1ns/1ps
`include "uart_regs.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
   failures++; $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module async_serial_port_bench;
   localparam int BIT = 32;
   logic CLK, RST_N, WR, RD;
   logic [3:0] ADDR;
   logic [15:0] WDATA;
   wire [15:0] RDATA;
   wire RXD, TXD_O, TXD_OE_N, TX_ACTIVE, IRQ;
   // Released pin floats to mark through the pull-up
   wire line = TXD_OE_N ? 1'b1 : TXD_O;
   int failures = 0;
   int check_count = 0;
   int run = 0;
   int last_low = 0;
   logic [15:0] rv;
   logic [8:0] ch;
   logic stop;
   async_serial_port dut (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR),
      .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .RXD(RXD),
      .TXD_O(TXD_O), .TXD_OE_N(TXD_OE_N), .TX_ACTIVE(TX_ACTIVE), .IRQ(IRQ));
   serial_peer #(.BIT(BIT)) peer (.clk(CLK), .line(line), .rxd(RXD));
   initial begin
      CLK = 1'b0;
      forever #4 CLK = ~CLK;
   end
   // Length of the latest low stretch, to time break frames
   always @(posedge CLK) begin
      if (!line)
         run <= run + 1;
      else begin
         if (run != 0)
            last_low <= run;
         run <= 0;
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
   endtask
   // Read data is taken just after the edge that registers it
   task automatic rd(input logic [3:0] a);
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      #1 rv = RDATA;
   endtask
   // status read arms the clear, so the data write drops the empty flag
   // in the same edge; a separate status write before it would let a bit
   // boundary in between ship the stale character still in the buffer
   task automatic send_tx(input logic [15:0] d);
      rd(`A_STAT);
      wr(`A_DATA, d);
   endtask
   function automatic logic [8:0] expect_ch(input logic [8:0] d,
         input int n, input logic pen, input logic odd);
      logic [8:0] m;
      m = d & ((9'h001 << (n - pen)) - 9'h001);
      if (pen)
         m[n - 1] = ^m ^ odd;
      return m;
   endfunction
   task automatic t_refuse();
      int lows;
      lows = 0;
      `CHK(TX_ACTIVE, 1'b0)
      rd(4'hE);
      `CHK(rv, 16'h0000)
      wr(`A_CTRL, 16'h0006);
      rd(`A_CTRL);
      `CHK(rv, 16'h0006)
      wr(`A_DATA, 16'h0000);
      repeat (25 * BIT) begin
         @(posedge CLK);
         lows += !line;
      end
      `CHK(lows, 0)
      rd(`A_STAT);
      `CHK(rv, 16'h0060)
      wr(`A_CTRL, 16'h0000);
      tick(4 * BIT);
      `CHK(TX_ACTIVE, 1'b0)
      $display("refuse test done");
   endtask
   // Every combination of nine_bit_sel and parity_enable, both parities
   task automatic t_tx_formats();
      logic [15:0] c;
      logic [8:0] d;
      int n;
      for (int f = 0; f < 4; f++) begin
         c = 16'h0006;
         c[`C_NINE] = f[1];
         c[`C_PEN] = f[0];
         c[`C_PODD] = f[0] ^ f[1];
         c[`C_ODS] = (f == 2);
         n = f[1] ? 9 : 8;
         d = 9'h1A5 ^ 9'(f);
         wr(`A_CTRL, c);
         send_tx({7'h00, d});
         if (f == 0) begin
            tick(9 * BIT);
            `CHK(line, 1'b1)
         end
         peer.catch(ch, n, stop);
         `CHK(ch, expect_ch(d, n, f[0], f[0] ^ f[1]))
         `CHK(stop, 1'b1)
         tick(2 * BIT);
         rd(`A_STAT);
         `CHK(rv[6:5], 2'b11)
         `CHK(TXD_OE_N, f == 2)
      end
      $display("transmit test done");
   endtask
   task automatic rx_case(input logic [8:0] c, input int n, input logic s,
         input logic [4:0] st);
      peer.send(c, n, s);
      rd(`A_STAT);
      `CHK(rv[4:0], st)
      rd(`A_DATA);
      `CHK(rv[8:0], c)
      rd(`A_STAT);
      `CHK(rv[4:0], 5'h00)
   endtask
   task automatic t_rx();
      wr(`A_CTRL, 16'h0006);
      rx_case(9'h03C, 8, 1'b1, 5'h10);
      rx_case(9'h0C3, 8, 1'b0, 5'h12);
      wr(`A_CTRL, 16'h0106);
      rx_case(9'h0C3, 8, 1'b1, 5'h10);
      rx_case(9'h043, 8, 1'b1, 5'h11);
      wr(`A_CTRL, 16'h0006);
      peer.send(9'h011, 8, 1'b1);
      peer.send(9'h022, 8, 1'b0);
      rd(`A_STAT);
      `CHK(rv[4:0], 5'h18)
      rd(`A_DATA);
      `CHK(rv[8:0], 9'h011)
      rd(`A_STAT);
      `CHK(rv[4:0], 5'h00)
      $display("receive test done");
   endtask
   task automatic t_irq();
      wr(`A_CTRL, 16'h000E);
      tick(2);
      `CHK(IRQ, 1'b0)
      peer.send(9'h05A, 8, 1'b1);
      tick(2);
      `CHK(IRQ, 1'b1)
      rd(`A_STAT);
      rd(`A_DATA);
      tick(2);
      `CHK(IRQ, 1'b0)
      wr(`A_CTRL, 16'h0026);
      tick(2);
      `CHK(IRQ, 1'b1)
      wr(`A_CTRL, 16'h0016);
      tick(2);
      `CHK(IRQ, 1'b1)
      $display("interrupt test done");
   endtask
   // Break held briefly must still give one whole zero frame
   task automatic t_break();
      wr(`A_CTRL, 16'h0007);
      tick(2 * BIT);
      wr(`A_CTRL, 16'h0006);
      tick(14 * BIT);
      `CHK(last_low, 10 * BIT)
      `CHK(line, 1'b1)
      rd(`A_STAT);
      `CHK(rv[5], 1'b1)
      $display("break test done");
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      RST_N = 1'b0;
      WR = 1'b0;
      RD = 1'b0;
      ADDR = 4'h0;
      WDATA = 16'h0000;
      repeat (2) @(posedge CLK);
      RST_N <= 1'b1;
      wr(`A_BAUD, 16'h0001);
      t_refuse();
      t_tx_formats();
      t_rx();
      t_irq();
      t_break();
      complete_run();
   end
   // Watchdog: all scenarios need about 6000 cycles
   initial begin
      repeat (40000) @(posedge CLK);
      failures++;
      complete_run();
   end
endmodule
